// *** core/opd_cfg.svh ***
// Constants for the output pacing and digital I/O block
`ifndef OPD_CFG_SVH
`define OPD_CFG_SVH
`define OPD_CLK_HZ 40_000_000
`define OPD_AO_MAX_HZ 1_000_000
`define OPD_AO_MIN_HZ 1
`define OPD_DIN_MAX_HZ 4_000_000
`define OPD_SETTLE_US 4
`define OPD_SETTLE_CYC ((`OPD_SETTLE_US * `OPD_CLK_HZ) / 1_000_000)
`define OPD_AO_MIN_DIV (`OPD_CLK_HZ / `OPD_AO_MAX_HZ)
`define OPD_AO_MAX_DIV (`OPD_CLK_HZ / `OPD_AO_MIN_HZ)
`define OPD_DIN_MIN_DIV ((`OPD_CLK_HZ + `OPD_DIN_MAX_HZ - 1) / `OPD_DIN_MAX_HZ)
`define OPD_SRC_INT_OUT 2'b00
`define OPD_SRC_EXT_OUT 2'b01
`define OPD_SRC_EXT_IN 2'b10
`define OPD_SRC_INT_IN 2'b11
`define OPD_DIN_ASYNC 2'b00
`define OPD_DIN_ONCE 2'b01
`define OPD_DIN_EVERY 2'b10
`define OPD_DIN_ONLY 2'b11
`define OPD_NCH 4
`define OPD_CODE_W 16
`define OPD_FRAME_W 80
`define OPD_SHIFT_BITS 64
`endif

// *** core/opd_core.sv ***
// Output pacing, converter update shifting and digital I/O top level
`timescale 1ns/1ps
`include "opd_cfg.svh"
// How it works
// - Four 16-bit outputs, updates at most 1 MHz
// - Waveform per channel; single writes only otherwise
// - Internal output clock ticks 1 Hz to 1 MHz
// - External output pin pulses pace updates
// - Input pin paces outputs and input scans
// - Internal input clock uses scan clock
// - Scan-paced: all channels and pattern together
// - Shift codes and settle within 4 us
// - Host stream consumed in order, one per tick
// - Output clock runs independent of scan timing
// - One common clock may pace everything
// - 24 lines, direction per 8-bit group
// - Digital inputs readable at any time
// - Two synchronous digital scan modes, no slowdown
// - Digital-only scans sample up to 4 MHz
// - Async digital output writes at any time
// - Pattern on two 8-bit ports, 4 MHz
// - Pattern clock 1 s to 4 MHz, independent
// - Digital sampled at scan start with analog
module opd_core #(
   parameter int DIV_W = 26
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pacing configuration
   input wire opd_pkg::opd_src_t ao_src,
   input wire logic [DIV_W-1:0] ao_div,
   input wire logic [DIV_W-1:0] scan_div,
   input wire logic [DIV_W-1:0] pat_div,
   input wire logic run,
   input wire logic [3:0] wave_en,
   input wire logic pat_en,
   input wire logic pat_on_scan,
   // External pacing pins
   input wire logic output_pace_pin,
   input wire logic input_pace_pin,
   // Host stream: four codes then 16-bit pattern, code 0 in low bits
   input wire logic [`OPD_FRAME_W-1:0] strm_data,
   input wire logic strm_valid,
   output logic strm_ready,
   // Host single writes
   input wire logic [1:0] sw_chan,
   input wire logic [`OPD_CODE_W-1:0] sw_code,
   input wire logic sw_wr,
   output logic sw_reject,
   // Converter serial link
   output logic dac_sclk,
   output logic dac_sdo,
   output logic dac_load,
   output logic [`OPD_NCH*`OPD_CODE_W-1:0] ao_code,
   output logic ao_busy,
   output logic underrun,
   input wire logic underrun_clr,
   // Scan timing
   output logic scan_start,
   // Digital I/O lines
   input wire logic [2:0] dio_dir_out,
   input wire logic [23:0] dio_in,
   output logic [23:0] dio_out,
   output logic [23:0] dio_oe,
   input wire logic [23:0] dout_data,
   input wire logic dout_wr,
   // Digital input reading and scanning
   input wire opd_pkg::opd_dmode_t din_mode,
   input wire logic adc_sample,
   output logic [23:0] din_now,
   output logic [23:0] din_scan,
   output logic din_scan_vld
);
   import opd_pkg::*;

   localparam int SB = `OPD_SHIFT_BITS;
   localparam logic [DIV_W-1:0] AO_MIN = DIV_W'(`OPD_AO_MIN_DIV);
   localparam logic [DIV_W-1:0] AO_MAX = DIV_W'(`OPD_AO_MAX_DIV);
   localparam logic [DIV_W-1:0] DIN_MIN = DIV_W'(`OPD_DIN_MIN_DIV);
   localparam logic [7:0] SETTLE = 8'(`OPD_SETTLE_CYC - 2 * SB);

   function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d,
      input logic [DIV_W-1:0] lo, input logic [DIV_W-1:0] hi);
      clamp_div = (d < lo) ? lo : ((d > hi) ? hi : d);
   endfunction : clamp_div

   logic ao_tick;
   logic scan_tick;
   logic pat_tick;
   logic out_rise;
   logic in_rise;
   logic [DIV_W-1:0] scan_lo;

   // Digital-only scans may run at 4 MHz, analog scans are 1 MHz bound
   assign scan_lo = (din_mode == `OPD_DIN_ONLY) ? DIN_MIN : AO_MIN;

   opd_ticker #(.W(DIV_W)) u_ao_clk (
      .clk_sys(clk_sys),
      .rst(rst),
      .en_i(run && ao_src == `OPD_SRC_INT_OUT),
      .div_i(clamp_div(ao_div, AO_MIN, AO_MAX)),
      .tick_o(ao_tick)
   );
   opd_ticker #(.W(DIV_W)) u_scan_clk (
      .clk_sys(clk_sys),
      .rst(rst),
      .en_i(run && ao_src != `OPD_SRC_EXT_IN),
      .div_i(clamp_div(scan_div, scan_lo, AO_MAX)),
      .tick_o(scan_tick)
   );
   opd_ticker #(.W(DIV_W)) u_pat_clk (
      .clk_sys(clk_sys),
      .rst(rst),
      .en_i(run && pat_en),
      .div_i(clamp_div(pat_div, DIN_MIN, AO_MAX)),
      .tick_o(pat_tick)
   );
   opd_pin_sync u_out_pin (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_i(output_pace_pin),
      .rise_o(out_rise)
   );
   opd_pin_sync u_in_pin (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_i(input_pace_pin),
      .rise_o(in_rise)
   );

   // Pacing selection
   logic scan_evt;
   logic upd_evt;
   always_comb
   begin
      scan_evt = run && ((ao_src == `OPD_SRC_EXT_IN) ? in_rise : scan_tick);
      case (ao_src)
         `OPD_SRC_INT_OUT: upd_evt = ao_tick;
         `OPD_SRC_EXT_OUT: upd_evt = run && out_rise;
         `OPD_SRC_EXT_IN: upd_evt = scan_evt;
         `OPD_SRC_INT_IN: upd_evt = scan_evt;
         default: upd_evt = 1'b0;
      endcase
   end

   // Update engine state
   opd_upd_e st_r;
   opd_upd_e st_nxt;
   logic [SB-1:0] sh_r;
   logic [SB-1:0] sh_nxt;
   logic [6:0] bit_r;
   logic [6:0] bit_nxt;
   logic [7:0] wait_r;
   logic [7:0] wait_nxt;
   logic sclk_r;
   logic sclk_nxt;
   logic load_r;
   logic load_nxt;
   logic [SB-1:0] code_r;
   logic [SB-1:0] code_nxt;
   logic [SB-1:0] pend_r;
   logic [SB-1:0] pend_nxt;
   logic [15:0] pat_r;
   logic [15:0] pat_nxt;
   logic [15:0] patq_r;
   logic [15:0] patq_nxt;
   logic patq_vld_r;
   logic patq_vld_nxt;
   logic [23:0] dout_r;
   logic [23:0] dout_nxt;
   logic urun_r;
   logic urun_nxt;
   logic rdy_r;
   logic rdy_nxt;
   logic rej_r;
   logic rej_nxt;
   logic start_r;
   logic start_nxt;
   logic take;
   logic pat_upd;

   always_comb
   begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      wait_nxt = wait_r;
      sclk_nxt = 1'b0;
      load_nxt = 1'b0;
      code_nxt = code_r;
      pend_nxt = pend_r;
      pat_nxt = pat_r;
      patq_nxt = patq_r;
      patq_vld_nxt = patq_vld_r;
      dout_nxt = dout_r;
      urun_nxt = urun_r;
      rej_nxt = 1'b0;
      start_nxt = scan_evt;
      // One frame per tick, in stream order
      take = upd_evt && strm_valid && rdy_r;
      // Pattern follows scan start or its own pacer
      pat_upd = pat_on_scan ? scan_evt : pat_tick;
      rdy_nxt = 1'b1;
      if (underrun_clr)
      begin
         urun_nxt = 1'b0;
      end
      if (upd_evt && !(strm_valid && rdy_r) && (wave_en != 4'h0 || pat_on_scan))
      begin
         urun_nxt = 1'b1;
      end
      if (take)
      begin
         rdy_nxt = 1'b0;
         for (int i = 0; i < `OPD_NCH; i++)
         begin
            if (wave_en[i])
            begin
               pend_nxt[i*16 +: 16] = strm_data[i*16 +: 16];
            end
         end
         patq_nxt = strm_data[SB +: 16];
         patq_vld_nxt = 1'b1;
      end
      if (sw_wr)
      begin
         if (wave_en[sw_chan])
         begin
            rej_nxt = 1'b1;
         end
         else
         begin
            pend_nxt[sw_chan*16 +: 16] = sw_code;
         end
      end
      // A frame taken on this scan start drives the pattern at once
      if (pat_upd && (take || patq_vld_r))
      begin
         pat_nxt = take ? strm_data[SB +: 16] : patq_r;
         patq_vld_nxt = 1'b0;
      end
      if (dout_wr)
      begin
         dout_nxt = dout_data;
      end
      if (pat_en)
      begin
         dout_nxt[15:0] = pat_nxt;
      end
      case (st_r)
         OPD_IDLE:
         begin
            if (take || (sw_wr && !wave_en[sw_chan]))
            begin
               st_nxt = OPD_SHIFT;
               sh_nxt = pend_nxt;
               bit_nxt = 7'(SB);
            end
         end
         OPD_SHIFT:
         begin
            sclk_nxt = ~sclk_r;
            if (sclk_r)
            begin
               sh_nxt = {sh_r[SB-2:0], 1'b0};
               bit_nxt = bit_r - 7'd1;
               if (bit_r == 7'd1)
               begin
                  st_nxt = OPD_SETTLE;
                  wait_nxt = SETTLE;
                  load_nxt = 1'b1;
                  code_nxt = pend_r;
               end
            end
         end
         OPD_SETTLE:
         begin
            wait_nxt = wait_r - 8'd1;
            if (wait_r <= 8'd1)
            begin
               st_nxt = OPD_IDLE;
            end
         end
         default: st_nxt = OPD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_r <= OPD_IDLE;
         sh_r <= '0;
         bit_r <= '0;
         wait_r <= '0;
         sclk_r <= 1'b0;
         load_r <= 1'b0;
         code_r <= '0;
         pend_r <= '0;
         pat_r <= '0;
         patq_r <= '0;
         patq_vld_r <= 1'b0;
         dout_r <= '0;
         urun_r <= 1'b0;
         rdy_r <= 1'b0;
         rej_r <= 1'b0;
         start_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         wait_r <= wait_nxt;
         sclk_r <= sclk_nxt;
         load_r <= load_nxt;
         code_r <= code_nxt;
         pend_r <= pend_nxt;
         pat_r <= pat_nxt;
         patq_r <= patq_nxt;
         patq_vld_r <= patq_vld_nxt;
         dout_r <= dout_nxt;
         urun_r <= urun_nxt;
         rdy_r <= rdy_nxt;
         rej_r <= rej_nxt;
         start_r <= start_nxt;
      end
   end

   // Digital input side
   logic [23:0] di1_r;
   logic [23:0] di2_r;
   logic [23:0] dnow_r;
   logic [23:0] dscan_r;
   logic [23:0] dscan_nxt;
   logic dvld_r;
   logic dvld_nxt;
   logic [23:0] oe_r;
   logic [23:0] oe_nxt;

   always_comb
   begin
      dscan_nxt = dscan_r;
      dvld_nxt = 1'b0;
      for (int g = 0; g < 3; g++)
      begin
         oe_nxt[g*8 +: 8] = {8{dio_dir_out[g]}};
      end
      case (din_mode)
         `OPD_DIN_ONCE: dvld_nxt = scan_evt;
         `OPD_DIN_EVERY: dvld_nxt = scan_evt || adc_sample;
         `OPD_DIN_ONLY: dvld_nxt = scan_evt;
         default: dvld_nxt = 1'b0;
      endcase
      if (dvld_nxt)
      begin
         dscan_nxt = di2_r;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         di1_r <= '0;
         di2_r <= '0;
         dnow_r <= '0;
         dscan_r <= '0;
         dvld_r <= 1'b0;
         oe_r <= '0;
      end
      else
      begin
         di1_r <= dio_in;
         di2_r <= di1_r;
         dnow_r <= di2_r;
         dscan_r <= dscan_nxt;
         dvld_r <= dvld_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign strm_ready = rdy_r;
   assign sw_reject = rej_r;
   assign dac_sclk = sclk_r;
   assign dac_sdo = sh_r[SB-1];
   assign dac_load = load_r;
   assign ao_code = code_r;
   assign ao_busy = (st_r != OPD_IDLE);
   assign underrun = urun_r;
   assign scan_start = start_r;
   assign dio_out = dout_r;
   assign dio_oe = oe_r;
   assign din_now = dnow_r;
   assign din_scan = dscan_r;
   assign din_scan_vld = dvld_r;
endmodule : opd_core

// *** core/opd_pin_sync.sv ***
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/1ps
module opd_pin_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pin
   input wire logic pin_i,
   // Result
   output logic rise_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic rise_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         rise_r <= 1'b0;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rise_r <= s2_r & ~s3_r;
      end
   end

   assign rise_o = rise_r;
endmodule : opd_pin_sync

// *** core/opd_pkg.sv ***
// Types for the output pacing and digital I/O block
package opd_pkg;
   typedef logic [1:0] opd_src_t;
   typedef logic [1:0] opd_dmode_t;
   typedef enum logic [1:0]
   {
      OPD_IDLE = 2'b00,
      OPD_SHIFT = 2'b01,
      OPD_SETTLE = 2'b10
   } opd_upd_e;
endpackage : opd_pkg

// *** core/opd_ticker.sv ***
// Programmable tick generator: one pulse every div_i cycles while enabled
`timescale 1ns/1ps
module opd_ticker #(
   parameter int W = 26
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic en_i,
   input wire logic [W-1:0] div_i,
   // Tick
   output logic tick_o
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (!en_i)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r + W'(1) >= div_i)
      begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
      end
      else
      begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;
endmodule : opd_ticker

// *** testbench/opd_core_asserts.sv ***
// Assertion checker for the output pacing block
`timescale 1ns/1ps
module opd_core_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Watched ports
   input wire logic [3:0] wave_en,
   input wire logic [1:0] sw_chan,
   input wire logic sw_wr,
   input wire logic sw_reject,
   input wire logic strm_ready,
   input wire logic dac_sclk,
   input wire logic dac_load,
   input wire logic [63:0] ao_code,
   input wire logic ao_busy,
   input wire logic underrun,
   input wire logic underrun_clr,
   input wire logic scan_start,
   input wire logic [2:0] dio_dir_out,
   input wire logic [23:0] dio_oe
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Cycles spent busy in the current update
   always_comb
   begin
      cnt_nxt = ao_busy ? cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_nxt;
   end
   a_busy_bound: assert property (ao_busy |-> cnt_r < 8'hA1)
      else $error("update busy too long");
   a_busy_min: assert property ($rose(ao_busy) |-> ao_busy [*8])
      else $error("update busy too short");
   a_load_late: assert property (dac_load |-> (ao_busy && cnt_r > 8'h70) ##1 !dac_load)
      else $error("load pulse misplaced");
   a_sclk_busy: assert property ($changed(dac_sclk) |-> ao_busy || $past(ao_busy))
      else $error("serial clock while idle");
   a_ready_back: assert property ($fell(strm_ready) |=> strm_ready)
      else $error("ready not restored");
   a_rej_cause: assert property (sw_wr && wave_en[sw_chan] |=> sw_reject)
      else $error("write not refused");
   a_rej_only: assert property (sw_reject |-> $past(sw_wr))
      else $error("refusal without write");
   a_under_stick: assert property (underrun && !underrun_clr |=> underrun)
      else $error("underrun lost");
   a_code_hold: assert property ($changed(ao_code) |-> dac_load || $past(dac_load))
      else $error("codes changed without load");
   a_scan_pulse: assert property (scan_start |=> !scan_start)
      else $error("scan start too long");
   a_oe_group: assert property ($stable(dio_dir_out) [*3] |->
      dio_oe == {{8{dio_dir_out[2]}}, {8{dio_dir_out[1]}}, {8{dio_dir_out[0]}}})
      else $error("group enable wrong");
   c_load: cover property (dac_load);
   c_reject: cover property (sw_reject);
   c_under: cover property ($rose(underrun));
   c_scan: cover property (scan_start);
endmodule : opd_core_chk

bind opd_core opd_core_chk opd_core_chk_inst (.clk_sys, .rst, .wave_en, .sw_chan, .sw_wr,
   .sw_reject, .strm_ready, .dac_sclk, .dac_load, .ao_code, .ao_busy, .underrun,
   .underrun_clr, .scan_start, .dio_dir_out, .dio_oe);

// *** testbench/opd_core_tb_top.sv ***
// Testbench for the output pacing block
`timescale 1ns/1ps
module opd_core_tb_top;
   import opd_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, run = 1'b0, pat_en = 1'b0, pat_on_scan = 1'b0;
   logic output_pace_pin = 1'b0, input_pace_pin = 1'b0, sw_wr = 1'b0, starve = 1'b0;
   logic underrun_clr = 1'b0, dout_wr = 1'b0, adc_sample = 1'b0, scan_seen = 1'b0;
   opd_src_t ao_src = 2'h0;
   opd_dmode_t din_mode = 2'h1;
   logic [25:0] ao_div = 26'h190, scan_div = 26'h190, pat_div = 26'h190;
   logic [3:0] wave_en = 4'h0;
   logic [1:0] sw_chan = 2'h0;
   logic [15:0] sw_code = 16'h0000, taken;
   logic [2:0] dio_dir_out = 3'h0;
   logic [23:0] dio_in = 24'h5A_0F3C, dout_data = 24'h00_0000;
   logic [79:0] strm_data;
   logic strm_valid, strm_ready, sw_reject, dac_sclk, dac_sdo, dac_load, ao_busy;
   logic underrun, scan_start, din_scan_vld;
   logic [63:0] ao_code;
   logic [23:0] dio_out, dio_oe, din_now, din_scan;
   int errors = 0, samples_checked = 0;
   opd_core #(.DIV_W(26)) opd_core_inst (.*);
   opd_host_model opd_host_model_inst (.*);
   always #12.5 clk_sys = ~clk_sys;
   task results;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
      samples_checked++;
      if (got !== ex)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      end
   endtask : chk
   // Wait for load (0), idle (1) or underrun (2)
   task wt(input logic [1:0] sel);
      logic [2:0] v;
      for (int i = 0; i < 2000; i++)
      begin
         @(posedge clk_sys);
         v = {underrun, !ao_busy, dac_load};
         if (v[sel] === 1'b1)
         begin
            repeat (2) @(negedge clk_sys);
            return;
         end
      end
      errors++;
      results();
   endtask : wt
   function automatic logic [63:0] fexp(input logic [15:0] k);
      return {16'h4000 + k, 16'h3000 + k, 16'h2000 + k, 16'h1000 + k};
   endfunction : fexp
   always @(negedge clk_sys)
   begin
      if (scan_start === 1'b1)
         scan_seen = 1'b1;
      if (din_scan_vld === 1'b1)
         chk("din_scan", {40'h0, dio_in}, {40'h0, din_scan});
   end
   initial
   begin
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      wave_en = 4'hF;
      run = 1'b1;
      repeat (2)
      begin
         wt(2'h0);
         chk("ao_code", fexp(taken - 16'h1), ao_code);
      end
      starve = 1'b1;
      wt(2'h2);
      chk("held", fexp(taken - 16'h1), ao_code);
      underrun_clr = 1'b1;
      starve = 1'b0;
      @(negedge clk_sys);
      underrun_clr = 1'b0;
      @(negedge clk_sys);
      chk("underrun", 64'h0, {63'h0, underrun});
      sw_chan = 2'h1;
      sw_wr = 1'b1;
      @(negedge clk_sys);
      sw_wr = 1'b0;
      chk("sw_reject", 64'h1, {63'h0, sw_reject});
      run = 1'b0;
      wave_en = 4'h0;
      wt(2'h1);
      sw_chan = 2'h2;
      sw_code = 16'hBEEF;
      sw_wr = 1'b1;
      @(negedge clk_sys);
      sw_wr = 1'b0;
      wt(2'h0);
      chk("single", 64'hBEEF, {48'h0, ao_code[47:32]});
      pat_en = 1'b1;
      pat_on_scan = 1'b1;
      dio_dir_out = 3'h3;
      for (int s = 1; s < 4; s++)
      begin
         wt(2'h1);
         ao_src = 2'(s);
         scan_seen = 1'b0;
         wave_en = 4'hF;
         run = 1'b1;
         repeat (3) @(negedge clk_sys);
         // Outside party pulses the selected pin
         output_pace_pin = (s == 1);
         input_pace_pin = (s == 2);
         repeat (3) @(negedge clk_sys);
         output_pace_pin = 1'b0;
         input_pace_pin = 1'b0;
         wt(2'h0);
         run = 1'b0;
         chk("paced", fexp(taken - 16'h1), ao_code);
         if (s > 1)
         begin
            chk("scan", 64'h1, {63'h0, scan_seen});
            chk("pattern", {48'h0, 16'hA4FF + taken}, {48'h0, dio_out[15:0]});
         end
      end
      pat_en = 1'b0;
      dio_dir_out = 3'h5;
      dio_in = 24'hC3_A5F0;
      dout_data = 24'h12_3456;
      dout_wr = 1'b1;
      @(negedge clk_sys);
      dout_wr = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("dio_oe", 64'hFF_00FF, {40'h0, dio_oe});
      chk("dio_out", 64'h12_0056, {40'h0, dio_out & dio_oe});
      chk("din_now", {40'h0, dio_in}, {40'h0, din_now});
      results();
   end
endmodule : opd_core_tb_top

// *** testbench/opd_host_model.sv ***
// Host stream model: numbered frames, one per take
`timescale 1ns/1ps
module opd_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bench control
   input wire logic starve,
   // Stream
   output logic [79:0] strm_data,
   output logic strm_valid,
   input wire logic strm_ready,
   // Frames handed over
   output logic [15:0] taken
);
   logic rdy_q;
   logic [79:0] frm;
   // Ready falling marks a take; next frame follows in order
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdy_q <= 1'b0;
         taken <= 16'h0000;
      end
      else
      begin
         rdy_q <= strm_ready;
         if (rdy_q && !strm_ready)
            taken <= taken + 16'h0001;
      end
   end
   assign frm = {16'hA500 + taken, 16'h4000 + taken, 16'h3000 + taken,
      16'h2000 + taken, 16'h1000 + taken};
   assign strm_valid = !starve && !rst;
   // Withheld data shows no stale frame
   assign strm_data = strm_valid ? frm : ~frm;
endmodule : opd_host_model
